// *** core/acs_config_top.sv ***
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
// Functional notes
// RL1: Reset pin low after reset: serial port
// RL2: Pin pulse or soft bit restores defaults
// RL3: Reset pin held high: pins are straps
// RL4: Clock strap picks reference and gain
// RL5: Select strap picks format and interface
// RL6: Data and power-down straps pick power
// RL7: Host pulses reset over 10 ns first
// RL8: Shift data on falling clock while selected
// RL9: Every 16th falling edge commits word
// RL10: Many words per frame; leftovers dropped
// RL11: Five address bits then eleven data bits
// RL12: Shift clock from 20 MHz to hertz
// RL13: Soft bit loads defaults, clears itself
// RL14: Host waits 5 ms after supplies
// RL15: Host waits 25 ns before selecting
// RL16: Unused bits written zero, multi-field writes
// RL17: Words sent most significant bit first
// RL18: Partial word dropped when select rises
module acs_config_top
  import acs_pkg::*;
#(
  parameter int STRAP_CYCLES = ACS_STRAP_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        link_clk,
  input  wire logic        reset_pin,
  input  wire logic        serial_select_n,
  input  wire logic        serial_in_line,
  input  wire logic        power_down_pin,
  input  wire logic [1:0]  strap_clk_level,
  input  wire logic [1:0]  strap_sel_level,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output acs_cfg_t         cfg_out,
  output logic             serial_mode,
  output logic             strap_mode
);

  typedef struct packed {
    acs_mode_t             mode;
    acs_regs_t             regs;
    logic [ACS_NPIN-1:0]   s1;
    logic [ACS_NPIN-1:0]   s2;
    logic [ACS_NPIN-1:0]   s3;
    logic [ACS_NPIN-1:0]   filt;
    logic                  tog_seen;
    logic [3:0]            warm;
    logic [15:0]           hold_cnt;
    logic [15:0]           wcount;
    logic                  ack;
    logic [31:0]           rdata;
    acs_cfg_t              cfg;
  } acs_sys_t;

  localparam logic [15:0] STRAP_HOLD = 16'(STRAP_CYCLES);
  localparam logic [15:0] RST_HOLD   = ACS_RST_MIN_CYC - 16'h1;

  acs_sys_t                state_reg;
  acs_sys_t                state_next;
  logic [ACS_WORD_W-1:0]   link_word;
  logic                    link_tog;
  logic [ACS_NPIN-1:0]     pins_raw;
  logic                    rst_lvl;
  logic [1:0]              clk_lvl;
  logic [1:0]              sel_lvl;
  logic                    pdn_lvl;
  logic                    dat_lvl;
  logic                    commit_ev;
  logic                    commit_ok;
  logic [ACS_ADDR_W-1:0]   word_addr;
  logic [ACS_DATA_W-1:0]   word_data;
  logic                    bus_req;
  logic [5:0]              bus_idx;

  // Link-side shifter on the serial clock
  acs_serial_rx u_rx (
    .link_clk        (link_clk),
    .serial_select_n (serial_select_n),
    .serial_in_line  (serial_in_line),
    .reset_pin       (reset_pin),
    .word_out        (link_word),
    .commit_tog      (link_tog)
  );

  // Pins and link event gathered for the three-stage sync
  assign pins_raw = {strap_sel_level, strap_clk_level, serial_in_line,
                     power_down_pin, link_tog, reset_pin};

  // Filtered levels
  assign rst_lvl   = state_reg.filt[ACS_PIN_RST];
  assign clk_lvl   = state_reg.filt[ACS_PIN_CLV +: 2];
  assign sel_lvl   = state_reg.filt[ACS_PIN_SLV +: 2];
  assign pdn_lvl   = state_reg.filt[ACS_PIN_PDN];
  assign dat_lvl   = state_reg.filt[ACS_PIN_DAT];
  assign commit_ev = state_reg.filt[ACS_PIN_TOG] != state_reg.tog_seen;
  assign commit_ok = commit_ev && !rst_lvl && state_reg.warm[3] &&
                     state_reg.mode == ACS_M_SERIAL;
  assign word_addr = link_word[ACS_WORD_W-1 -: ACS_ADDR_W];   // [RL11]
  assign word_data = link_word[ACS_DATA_W-1:0];               // [RL11]
  assign bus_req   = avs_read || avs_write;
  assign bus_idx   = avs_address[7:2];

  // Register write with self-clearing reinit bit
  function automatic acs_regs_t acs_apply(
    input acs_regs_t             cur,
    input logic [ACS_ADDR_W-1:0] a,
    input logic [ACS_DATA_W-1:0] d
  );
    acs_regs_t r;
    r = cur;
    if (a == ACS_REG_MAIN && d[ACS_BIT_SOFT_INIT]) begin
      r = ACS_REGS_DEFAULT;                                   // [RL13]
    end else begin
      r[a] = d;
    end
    return r;
  endfunction : acs_apply

  // Next-state logic
  always_comb begin
    logic [ACS_DATA_W-1:0] merged;
    acs_cfg_t              dec;
    merged     = '0;
    dec        = '0;
    state_next = state_reg;

    // Three-stage sync; a level counts once stages two and three agree
    state_next.s1 = pins_raw;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    state_next.filt = ((state_reg.s2 ~^ state_reg.s3) & state_reg.s3) |
                      ((state_reg.s2 ^ state_reg.s3) & state_reg.filt);
    state_next.tog_seen = state_reg.filt[ACS_PIN_TOG];

    // Edge detector tracks the sync until every stage holds the pin,
    // so a link toggle left high cannot fake a commit after reset
    state_next.warm = {state_reg.warm[2:0], 1'b1};
    if (!state_reg.warm[3]) begin
      state_next.tog_seen = state_next.filt[ACS_PIN_TOG];
    end

    // Time the reset pin high to tell a pulse from a tie-off
    if (rst_lvl) begin
      if (state_reg.hold_cnt != 16'hffff) begin
        state_next.hold_cnt = state_reg.hold_cnt + 16'h1;
      end
    end else begin
      state_next.hold_cnt = 16'h0;
    end

    // Mode machine
    case (state_reg.mode)
      ACS_M_RESET: begin
        if (!rst_lvl) begin
          state_next.mode = ACS_M_SERIAL;                     // [RL1]
        end else if (state_reg.hold_cnt >= STRAP_HOLD) begin
          state_next.mode = ACS_M_STRAP;                      // [RL3]
        end
      end
      ACS_M_SERIAL: begin
        if (rst_lvl) begin
          state_next.mode = ACS_M_RESET;
        end
      end
      ACS_M_STRAP: begin
        if (!rst_lvl) begin
          state_next.mode = ACS_M_SERIAL;                     // [RL1]
        end
      end
      default: begin
        state_next.mode = ACS_M_RESET;
      end
    endcase

    // Bus handshake: one wait cycle, answer in the next
    state_next.ack = bus_req && !state_reg.ack;
    if (bus_req && !state_reg.ack) begin
      if (bus_idx < ACS_IDX_STATUS) begin
        state_next.rdata = {21'h0, state_reg.regs[bus_idx[4:0]]};
      end else if (bus_idx == ACS_IDX_STATUS) begin
        state_next.rdata = {21'h0, state_reg.cfg,
                            state_reg.mode == ACS_M_STRAP,
                            state_reg.mode == ACS_M_SERIAL, rst_lvl};
      end else if (bus_idx == ACS_IDX_WCOUNT) begin
        state_next.rdata = {16'h0, state_reg.wcount};
      end else begin
        state_next.rdata = 32'h0;
      end
    end

    // Bus write to a configuration register, byte lanes honoured
    if (state_reg.ack && avs_write && bus_idx < ACS_IDX_STATUS) begin
      merged = state_reg.regs[bus_idx[4:0]];
      if (avs_byteenable[0]) begin
        merged[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        merged[10:8] = avs_writedata[10:8];
      end
      state_next.regs = acs_apply(state_next.regs, bus_idx[4:0], merged);
    end

    // Serial word commit, applied after the bus so it wins
    if (commit_ok) begin
      state_next.regs = acs_apply(state_next.regs, word_addr,
                                  word_data);                 // [RL9]
      state_next.wcount = state_reg.wcount + 16'h1;
    end

    // Reset pin held high keeps every register at default
    if (rst_lvl && state_reg.hold_cnt >= RST_HOLD) begin
      state_next.regs = ACS_REGS_DEFAULT;                     // [RL2]
    end

    // Decode the active configuration
    if (state_reg.mode == ACS_M_STRAP) begin
      dec.internal_ref = clk_lvl == ACS_LVL_GND ||
                         clk_lvl == ACS_LVL_FULL;             // [RL4]
      dec.coarse_gain  = clk_lvl == ACS_LVL_5_8 ||
                         clk_lvl == ACS_LVL_FULL;             // [RL4]
      dec.straight_bin = sel_lvl == ACS_LVL_3_8 ||
                         sel_lvl == ACS_LVL_5_8;              // [RL5]
      dec.cmos_if      = sel_lvl == ACS_LVL_5_8 ||
                         sel_lvl == ACS_LVL_FULL;             // [RL5]
      dec.adc_standby  = pdn_lvl && !dat_lvl;                 // [RL6]
      dec.obuf_pdn     = dat_lvl && !pdn_lvl;                 // [RL6]
      dec.global_pdn   = dat_lvl && pdn_lvl;                  // [RL6]
      dec.clkout_pdn   = 1'b0;
    end else begin
      dec.internal_ref =
        !state_reg.regs[ACS_REG_MAIN][ACS_BIT_EXT_REF];
      dec.coarse_gain  = state_reg.regs[ACS_REG_MAIN][ACS_BIT_COARSE];
      dec.cmos_if      = state_reg.regs[ACS_REG_MAIN][ACS_BIT_CMOS];
      dec.straight_bin = state_reg.regs[ACS_REG_FMT][ACS_BIT_FMT_BIN];
      dec.adc_standby  = state_reg.regs[ACS_REG_MAIN][ACS_BIT_STBY];
      dec.obuf_pdn     = state_reg.regs[ACS_REG_MAIN][ACS_BIT_OBUF_PDN];
      dec.global_pdn   = 1'b0;
      dec.clkout_pdn   =
        state_reg.regs[ACS_REG_MAIN][ACS_BIT_CLKOUT_PDN];
    end
    state_next.cfg = dec;
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg          <= '0;
      state_reg.mode     <= ACS_M_RESET;
      state_reg.regs     <= ACS_REGS_DEFAULT;
      state_reg.cfg      <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign avs_waitrequest = bus_req && !state_reg.ack;
  assign avs_readdata    = state_reg.rdata;
  assign cfg_out         = state_reg.cfg;
  assign serial_mode     = state_reg.mode == ACS_M_SERIAL;
  assign strap_mode      = state_reg.mode == ACS_M_STRAP;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_pin_reset_regs: assert property (                          // [RL2]
    (rst_lvl && state_reg.hold_cnt >= RST_HOLD) |=>
      (state_reg.regs == ACS_REGS_DEFAULT))
    else $error("reset pin did not restore defaults");
  a_drop_in_reset: assert property (                           // [RL2]
    (commit_ev && rst_lvl) |=> $stable(state_reg.wcount))
    else $error("serial word taken while reset pin high");
  a_soft_reinit: assert property (                             // [RL13]
    (commit_ok && word_addr == ACS_REG_MAIN &&
     word_data[ACS_BIT_SOFT_INIT]) |=>
      (state_reg.regs == ACS_REGS_DEFAULT &&
       !state_reg.regs[ACS_REG_MAIN][ACS_BIT_SOFT_INIT]))
    else $error("soft reinit did not load defaults");
  a_serial_commit: assert property (                           // [RL9]
    (commit_ok && !(word_addr == ACS_REG_MAIN &&
                    word_data[ACS_BIT_SOFT_INIT])) |=>
      (state_reg.regs[$past(word_addr)] == $past(word_data) &&
       state_reg.wcount == $past(state_reg.wcount) + 16'h1))
    else $error("serial word not committed");
  a_strap_holds: assert property (                             // [RL3]
    (strap_mode && $past(strap_mode)) |->
      (state_reg.regs == ACS_REGS_DEFAULT && state_reg.hold_cnt >= STRAP_HOLD))
    else $error("strap mode with live registers");
  a_serial_entry: assert property (                            // [RL1]
    (!rst_lvl) |=> serial_mode)
    else $error("serial mode not entered with reset pin low");
  a_strap_ref_gain: assert property (                          // [RL4]
    strap_mode |=>
      (cfg_out.internal_ref == ($past(clk_lvl) == ACS_LVL_GND ||
                                $past(clk_lvl) == ACS_LVL_FULL) &&
       cfg_out.coarse_gain == $past(clk_lvl[1])))
    else $error("clock strap decoded wrongly");
  a_strap_fmt_if: assert property (                            // [RL5]
    strap_mode |=>
      (cfg_out.cmos_if == $past(sel_lvl[1]) &&
       cfg_out.straight_bin == ^$past(sel_lvl)))
    else $error("select strap decoded wrongly");
  a_strap_power: assert property (                             // [RL6]
    strap_mode |=>
      ({cfg_out.global_pdn, cfg_out.obuf_pdn, cfg_out.adc_standby} ==
       {$past(dat_lvl) && $past(pdn_lvl), $past(dat_lvl) && !$past(pdn_lvl),
        !$past(dat_lvl) && $past(pdn_lvl)}))
    else $error("power strap decoded wrongly");

  c_strap_mode: cover property ($rose(strap_mode));
  c_soft_reinit: cover property (commit_ok && word_addr == ACS_REG_MAIN &&
                                 word_data[ACS_BIT_SOFT_INIT]);
  c_serial_commit: cover property (commit_ok);
  c_bus_read: cover property (avs_read && !avs_waitrequest);

endmodule : acs_config_top

// *** core/acs_serial_rx.sv ***
`timescale 1ns/1ps
module acs_serial_rx
  import acs_pkg::*;
(
  input  wire logic                  link_clk,
  input  wire logic                  serial_select_n,
  input  wire logic                  serial_in_line,
  input  wire logic                  reset_pin,
  output logic      [ACS_WORD_W-1:0] word_out,
  output logic                       commit_tog
);

  acs_shift_t sh_reg;
  acs_shift_t sh_next;
  acs_hold_t  hd_reg;
  acs_hold_t  hd_next;

  // Bit count and shift; a high select drops a partial word
  always_comb begin
    sh_next = sh_reg;
    hd_next = hd_reg;
    sh_next.shift = {sh_reg.shift[13:0], serial_in_line};  // [RL8] [RL17]
    sh_next.cnt = sh_reg.cnt + 4'h1;
    if (sh_reg.cnt == ACS_LAST_BIT) begin                    // [RL9] [RL10]
      sh_next.cnt = 4'h0;
      hd_next.word = {sh_reg.shift, serial_in_line};
      hd_next.tog = ~hd_reg.tog;
    end
  end

  // Counter clears while deselected, no edge needed
  always_ff @(negedge link_clk or posedge serial_select_n) begin
    if (serial_select_n) begin
      sh_reg <= '0;                                          // [RL18]
    end else begin
      sh_reg <= sh_next;                                     // [RL12]
    end
  end

  // Held word and event toggle
  always_ff @(negedge link_clk or posedge reset_pin) begin
    if (reset_pin) begin
      hd_reg <= '0;
    end else begin
      hd_reg <= hd_next;
    end
  end

  assign word_out   = hd_reg.word;
  assign commit_tog = hd_reg.tog;

  a_word_msb_first: assert property (                        // [RL17]
    @(negedge link_clk) disable iff (serial_select_n || reset_pin)
    (sh_reg.cnt == ACS_LAST_BIT) |=>
      (hd_reg.word == {$past(sh_reg.shift), $past(serial_in_line)}))
    else $error("committed word not msb first");
  a_commit_on_16th: assert property (                        // [RL9]
    @(negedge link_clk) disable iff (serial_select_n || reset_pin)
    (sh_reg.cnt != ACS_LAST_BIT) |=> $stable(hd_reg.tog))
    else $error("commit before sixteenth bit");
  a_count_wraps: assert property (                           // [RL10]
    @(negedge link_clk) disable iff (serial_select_n || reset_pin)
    (sh_reg.cnt == ACS_LAST_BIT) |=>
      (sh_reg.cnt == 4'h0 && hd_reg.tog != $past(hd_reg.tog)))
    else $error("bit counter did not restart after word");

endmodule : acs_serial_rx

// *** shared/acs_pkg.sv ***
package acs_pkg;

  // Serial word layout
  localparam int ACS_ADDR_W = 5;
  localparam int ACS_DATA_W = 11;
  localparam int ACS_WORD_W = 16;
  localparam int ACS_NREG   = 32;
  localparam logic [3:0] ACS_LAST_BIT = 4'hf;   // 16th falling edge

  // Configuration register addresses and field positions
  localparam logic [4:0] ACS_REG_MAIN = 5'h00;
  localparam logic [4:0] ACS_REG_FMT  = 5'h0a;
  localparam int ACS_BIT_OBUF_PDN   = 10;
  localparam int ACS_BIT_COARSE     = 9;
  localparam int ACS_BIT_CMOS       = 8;
  localparam int ACS_BIT_EXT_REF    = 5;
  localparam int ACS_BIT_SOFT_INIT  = 4;
  localparam int ACS_BIT_CLKOUT_PDN = 2;
  localparam int ACS_BIT_STBY       = 0;
  localparam int ACS_BIT_FMT_BIN    = 10;
  localparam logic [10:0] ACS_REG_RESET = 11'h000;

  typedef logic [ACS_NREG-1:0][ACS_DATA_W-1:0] acs_regs_t;
  localparam acs_regs_t ACS_REGS_DEFAULT = {ACS_NREG{ACS_REG_RESET}};

  // Bus map, word indices (byte address is four times the index)
  localparam logic [5:0] ACS_IDX_REG0   = 6'h00;
  localparam logic [5:0] ACS_IDX_STATUS = 6'h20;
  localparam logic [5:0] ACS_IDX_WCOUNT = 6'h21;

  // Quantised strap pin levels
  localparam logic [1:0] ACS_LVL_GND  = 2'h0;
  localparam logic [1:0] ACS_LVL_3_8  = 2'h1;
  localparam logic [1:0] ACS_LVL_5_8  = 2'h2;
  localparam logic [1:0] ACS_LVL_FULL = 2'h3;

  // Synchronised pin vector positions
  localparam int ACS_NPIN    = 8;
  localparam int ACS_PIN_RST = 0;
  localparam int ACS_PIN_TOG = 1;
  localparam int ACS_PIN_PDN = 2;
  localparam int ACS_PIN_DAT = 3;
  localparam int ACS_PIN_CLV = 4;
  localparam int ACS_PIN_SLV = 6;

  // Timing
  localparam int ACS_CLK_NS     = 10;
  localparam int ACS_RST_MIN_NS = 10;
  localparam int ACS_RST_MIN_CYC_I =
    (ACS_RST_MIN_NS + ACS_CLK_NS - 1) / ACS_CLK_NS;
  localparam logic [15:0] ACS_RST_MIN_CYC =
    16'(ACS_RST_MIN_CYC_I < 1 ? 1 : ACS_RST_MIN_CYC_I);
  localparam int ACS_STRAP_NS   = 10000;
  localparam int ACS_STRAP_CYC  = ACS_STRAP_NS / ACS_CLK_NS;

  typedef enum logic [2:0] {
    ACS_M_RESET  = 3'b001,
    ACS_M_SERIAL = 3'b010,
    ACS_M_STRAP  = 3'b100
  } acs_mode_t;

  typedef struct packed {
    logic clkout_pdn;
    logic global_pdn;
    logic obuf_pdn;
    logic adc_standby;
    logic straight_bin;
    logic cmos_if;
    logic coarse_gain;
    logic internal_ref;
  } acs_cfg_t;

  // Link-side state
  typedef struct packed {
    logic [3:0]  cnt;
    logic [14:0] shift;
  } acs_shift_t;

  typedef struct packed {
    logic [ACS_WORD_W-1:0] word;
    logic                  tog;
  } acs_hold_t;

endpackage : acs_pkg

// *** test/acs_config_top_tb.sv ***
`timescale 1ns/1ps
module acs_config_top_tb;
  import acs_pkg::*;
  localparam int STRAP_N = 20;
  logic        clk_sys, rst, power_down_pin;
  logic        link_clk, reset_pin, serial_select_n, serial_in_line;
  logic [1:0]  strap_clk_level, strap_sel_level;
  logic [7:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  acs_cfg_t    cfg_out;
  logic        serial_mode, strap_mode;
  int          n_mismatch = 0;
  int          num_checks = 0;

  acs_config_top #(.STRAP_CYCLES(STRAP_N)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .link_clk(link_clk),
    .reset_pin(reset_pin), .serial_select_n(serial_select_n),
    .serial_in_line(serial_in_line), .power_down_pin(power_down_pin),
    .strap_clk_level(strap_clk_level), .strap_sel_level(strap_sel_level),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cfg_out(cfg_out),
    .serial_mode(serial_mode), .strap_mode(strap_mode));

  acs_host_model #(.PWR_WAIT_NS(203)) u_host (
    .link_clk(link_clk), .serial_select_n(serial_select_n),
    .serial_in_line(serial_in_line), .reset_pin(reset_pin));

  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task final_report();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  task wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_cyc

  // One bus cycle, held until waitrequest is seen low
  task bus_xfer(input logic wr, input logic [7:0] a,
                input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus_xfer

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus_xfer(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask : rd_chk

  task t_init();
    u_host.pulse_reset();
    wait_cyc(10);
    chk(32'(serial_mode), 32'h1);
    chk(32'(strap_mode), 32'h0);
    chk(32'(cfg_out), 32'h01);
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h84, 32'h0);
  endtask : t_init

  // Two words plus fifteen stray bits in one frame
  task t_frame();
    u_host.sel_low();
    u_host.shift_word(16'h0300);
    u_host.shift_word(16'h5400);
    for (int i = 15; i >= 1; i--) u_host.shift_bit(1'(16'h1ffe >> i));
    u_host.sel_high();
    power_down_pin <= 1'b1;          // Straps ignored in serial mode
    strap_clk_level <= 2'h2;
    strap_sel_level <= 2'h1;
    wait_cyc(10);
    rd_chk(8'h00, 32'h300);
    rd_chk(8'h28, 32'h400);
    rd_chk(8'h0c, 32'h0);
    rd_chk(8'h84, 32'h2);
    chk(32'(cfg_out), 32'h0f);
    rd_chk(8'h80, 32'h7a);
  endtask : t_frame

  task t_partial();
    u_host.sel_low();
    for (int i = 15; i >= 6; i--) u_host.shift_bit(1'(16'h1fff >> i));
    u_host.sel_high();
    rd_chk(8'h84, 32'h2);
    u_host.sel_low();
    u_host.shift_word(16'h1923);
    u_host.sel_high();
    wait_cyc(10);
    rd_chk(8'h0c, 32'h123);
  endtask : t_partial

  // Slow, lopsided shift clock
  task t_slow();
    u_host.t_hi = 400.0;
    u_host.t_lo = 60.0;
    u_host.sel_low();
    u_host.shift_word(16'h3aaa);
    u_host.sel_high();
    u_host.t_hi = 7.5;
    u_host.t_lo = 7.5;
    wait_cyc(10);
    rd_chk(8'h1c, 32'h2aa);
    rd_chk(8'h84, 32'h4);
  endtask : t_slow

  task t_soft();
    u_host.sel_low();
    u_host.shift_word(16'h0010);
    u_host.sel_high();
    wait_cyc(10);
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h28, 32'h0);
    rd_chk(8'h1c, 32'h0);
    chk(32'(cfg_out), 32'h01);
  endtask : t_soft

  // Bus writes, byte lanes, unmapped read
  task t_bus();
    bus_xfer(1'b1, 8'h14, 32'hffff_ffff, rd);
    rd_chk(8'h14, 32'h7ff);
    avs_byteenable <= 4'h1;
    bus_xfer(1'b1, 8'h18, 32'h0000_07ff, rd);
    avs_byteenable <= 4'hf;
    rd_chk(8'h18, 32'h0ff);
    rd_chk(8'hfc, 32'h0);
    // Lane one alone, then lane zero, into the main register
    avs_byteenable <= 4'h2;
    bus_xfer(1'b1, 8'h00, 32'h0000_0425, rd);
    avs_byteenable <= 4'h1;
    bus_xfer(1'b1, 8'h00, 32'h0000_0425, rd);
    avs_byteenable <= 4'hf;
    wait_cyc(2);
    rd_chk(8'h00, 32'h425);
    chk(32'(cfg_out), 32'hb0);
  endtask : t_bus

  // System reset in mid-run; the link keeps its toggle across it
  task t_sysrst();
    @(posedge clk_sys);
    rst <= 1'b1;
    wait_cyc(2);
    rst <= 1'b0;
    chk(32'(serial_mode), 32'h0);
    wait_cyc(10);
    chk(32'(serial_mode), 32'h1);
    chk(32'(cfg_out), 32'h01);
    rd_chk(8'h84, 32'h0);
    rd_chk(8'h00, 32'h0);
  endtask : t_sysrst

  task t_strap();
    logic [1:0] e_ck [4];
    logic [1:0] e_sl [4];
    logic [2:0] e_pw [3];
    e_ck = '{2'h1, 2'h0, 2'h2, 2'h3};
    e_sl = '{2'h0, 2'h2, 2'h3, 2'h1};
    e_pw = '{3'h0, 3'h1, 3'h2};
    u_host.set_strap(1'b0);
    wait_cyc(STRAP_N + 20);
    chk(32'(strap_mode), 32'h1);
    chk(32'(serial_mode), 32'h0);
    for (int i = 0; i < 4; i++) begin
      strap_clk_level <= 2'(i);
      strap_sel_level <= 2'(i);
      u_host.set_strap(i[1]);
      power_down_pin <= i[0];
      wait_cyc(10);
      chk(32'(cfg_out[1:0]), 32'(e_ck[i]));
      chk(32'(cfg_out[3:2]), 32'(e_sl[i]));
      if (i < 3) chk(32'(cfg_out[6:4]), 32'(e_pw[i]));
      else chk(32'(cfg_out[6]), 32'h1);
    end
  endtask : t_strap

  // Hang guard
  initial begin
    #300000;
    n_mismatch++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    power_down_pin = 1'b0;
    strap_clk_level = 2'h0;
    strap_sel_level = 2'h0;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    wait_cyc(5);
    rst <= 1'b0;
    wait_cyc(2);
    t_init();
    t_frame();
    t_partial();
    t_slow();
    t_soft();
    t_bus();
    t_sysrst();
    t_strap();
    final_report();
  end
endmodule : acs_config_top_tb

// *** test/acs_host_model.sv ***
`timescale 1ns/1ps
module acs_host_model #(
  parameter int PWR_WAIT_NS = 5000000
) (
  output logic link_clk,
  output logic serial_select_n,
  output logic serial_in_line,
  output logic reset_pin
);
  real t_hi = 7.5;
  real t_lo = 7.5;

  // Idle pins, link clock parked low
  initial begin
    link_clk = 1'b0;
    serial_select_n = 1'b1;
    serial_in_line = 1'b0;
    reset_pin = 1'b0;
  end

  // Supply settle, then reset pulse, then gap before select
  task pulse_reset();
    #(PWR_WAIT_NS);
    reset_pin = 1'b1;
    #40;
    reset_pin = 1'b0;
    #100;
  endtask : pulse_reset

  // Open a frame with select setup
  task sel_low();
    serial_select_n = 1'b0;
    #30;
  endtask : sel_low

  // Data changes mid low phase, device samples on the fall
  task shift_bit(input logic b);
    #(t_lo / 2);
    serial_in_line = b;
    #(t_lo / 2);
    link_clk = 1'b1;
    #(t_hi);
    link_clk = 1'b0;
  endtask : shift_bit

  // One word, address then data, MSB first
  task shift_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      shift_bit(w[i]);
    end
  endtask : shift_word

  // Close the frame; released data line shows the inverse
  task sel_high();
    #30;
    serial_select_n = 1'b1;
    serial_in_line = ~serial_in_line;
    #30;
  endtask : sel_high

  // Reset pin tied high, data line used as strap
  task set_strap(input logic d);
    reset_pin <= 1'b1;
    serial_in_line <= d;
  endtask : set_strap
endmodule : acs_host_model
